/* rtl/pkfm_pkg.sv */
// Operation
// - Two-bit field picks phase A, B or C voltage for line frequency.
// - Bits 2..4 enable per-phase peak capture; holds keep largest absolute sample.
// - Capture interval length equals the programmed half-line cycle count.
// - At interval end, peak holds are overwritten with that interval's peaks.
// - Voltage and current peaks are tracked independently across enabled phases.
// - Bits 5..7 enable per-phase alarm monitoring of absolute samples.
// - Any combination of alarm phase bits may be active concurrently.
// - Absolute sample above its threshold sets the matching sticky status flag.
`default_nettype none
package pkfm_pkg;
  localparam int SAMPLE_W = 24;
  localparam int NPHASE = 3;
  // APB byte addresses.
  localparam logic [7:0] ADDR_MEASUREMENT_MODE_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_HALFCYC = 8'h40;
  localparam logic [7:0] ADDR_VTHR = 8'h44;
  localparam logic [7:0] ADDR_ITHR = 8'h48;
  localparam logic [7:0] ADDR_VOLTAGE_PEAK_HOLD = 8'h4c;
  localparam logic [7:0] ADDR_CURRENT_PEAK_HOLD = 8'h50;
  localparam logic [7:0] ADDR_STATUS = 8'h54;
  localparam logic [7:0] ADDR_MASK = 8'h58;
  // Measurement mode fields and reset value.
  localparam int FREQ_LSB = 0;
  localparam int PKSEL_LSB = 2;
  localparam int ALSEL_LSB = 5;
  localparam logic [7:0] MEASUREMENT_MODE_CONFIG_RST = 8'hfc;
  localparam logic [15:0] HALFCYC_RST = 16'hffff;
  // Status bits: 0..2 voltage alarm A..C, 3..5 current alarm A..C, 6 interval done.
  localparam int ST_W = 7;
  localparam int ST_IAL = 3;
  localparam int ST_DONE = 6;
  typedef enum logic [1:0] {PKFM_PH_A, PKFM_PH_B, PKFM_PH_C, PKFM_PH_RSV} pkfm_phase_t;
endpackage
`default_nettype wire

/* rtl/pkfm_smp_if.sv */
`default_nettype none
// Per-phase sample bus shared between the top and the peak tracker.
interface pkfm_smp_if;
  import pkfm_pkg::*;
  logic [SAMPLE_W-1:0] v_abs [NPHASE];
  logic [SAMPLE_W-1:0] i_abs [NPHASE];
  logic valid;
  modport src (output v_abs, output i_abs, output valid);
  modport snk (input v_abs, input i_abs, input valid);
endinterface
`default_nettype wire

/* rtl/pkfm_peak.sv */
`default_nettype none
module pkfm_peak import pkfm_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  pkfm_smp_if.snk smp,
  input wire logic [NPHASE-1:0] phase_en,
  input wire logic interval_end,
  output logic [SAMPLE_W-1:0] v_hold,
  output logic [SAMPLE_W-1:0] i_hold
);
  typedef struct packed {
    logic [SAMPLE_W-1:0] v_run;
    logic [SAMPLE_W-1:0] i_run;
    logic [SAMPLE_W-1:0] v_hold;
    logic [SAMPLE_W-1:0] i_hold;
  } pkfm_pk_t;
  pkfm_pk_t st_ff, nxt_st;
  logic [SAMPLE_W-1:0] v_max, i_max;

  ////////////////////////////////////////////////////////////////////////
  // Running peak raised by any larger enabled sample this cycle; voltage and current chosen separately.
  always_comb begin
    v_max = st_ff.v_run;
    i_max = st_ff.i_run;
    for (int p = 0; p < NPHASE; p++) begin
      if (smp.valid && phase_en[p] && smp.v_abs[p] > v_max) v_max = smp.v_abs[p];
      if (smp.valid && phase_en[p] && smp.i_abs[p] > i_max) i_max = smp.i_abs[p];
    end
  end

  // Interval end publishes the running peaks and restarts the search.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.v_run = v_max;
    nxt_st.i_run = i_max;
    if (interval_end) begin
      nxt_st.v_hold = v_max;
      nxt_st.i_hold = i_max;
      nxt_st.v_run = '0;
      nxt_st.i_run = '0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign v_hold = st_ff.v_hold;
  assign i_hold = st_ff.i_hold;
endmodule // pkfm_peak
`default_nettype wire

/* rtl/pkfm_top.sv */
`default_nettype none
module pkfm_top import pkfm_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SAMPLE_W-1:0] v_abs_a,
  input wire logic [SAMPLE_W-1:0] v_abs_b,
  input wire logic [SAMPLE_W-1:0] v_abs_c,
  input wire logic [SAMPLE_W-1:0] i_abs_a,
  input wire logic [SAMPLE_W-1:0] i_abs_b,
  input wire logic [SAMPLE_W-1:0] i_abs_c,
  input wire logic sample_valid,
  input wire logic [NPHASE-1:0] zero_cross,
  output logic [1:0] line_freq_phase,
  output logic line_freq_zc,
  output logic irq
);
  typedef struct packed {
    logic [7:0] measurement_mode_config;
    logic [15:0] halfcyc;
    logic [SAMPLE_W-1:0] vthr;
    logic [SAMPLE_W-1:0] ithr;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [15:0] hc_cnt;
    logic [31:0] rdata;
    logic zc_out;
  } pkfm_st_t;
  pkfm_st_t st_ff, nxt_st;

  pkfm_smp_if smp ();
  logic [SAMPLE_W-1:0] v_hold, i_hold;
  logic [2:0] pk_en, al_en;
  logic [1:0] fsel;
  logic src_zc, interval_end, wr, rd;
  logic [ST_W-1:0] ev;

  ////////////////////////////////////////////////////////////////////////
  // Field decode of the measurement mode register.
  assign fsel = st_ff.measurement_mode_config[FREQ_LSB +: 2];
  assign pk_en = st_ff.measurement_mode_config[PKSEL_LSB +: NPHASE];
  assign al_en = st_ff.measurement_mode_config[ALSEL_LSB +: NPHASE];

  // Samples fan into the shared bus.
  assign smp.v_abs[0] = v_abs_a;
  assign smp.v_abs[1] = v_abs_b;
  assign smp.v_abs[2] = v_abs_c;
  assign smp.i_abs[0] = i_abs_a;
  assign smp.i_abs[1] = i_abs_b;
  assign smp.i_abs[2] = i_abs_c;
  assign smp.valid = sample_valid;

  // Reserved source code falls back to phase A rather than leaving the path floating.
  always_comb begin
    unique case (pkfm_phase_t'(fsel))
      PKFM_PH_A: src_zc = zero_cross[0];
      PKFM_PH_B: src_zc = zero_cross[1];
      PKFM_PH_C: src_zc = zero_cross[2];
      PKFM_PH_RSV: src_zc = zero_cross[0];
    endcase
  end

  // An interval ends when the chosen phase reaches the programmed half-cycle count.
  // A count of zero is treated as one so the interval can never stall.
  assign interval_end = src_zc && (st_ff.hc_cnt + 16'h0001 >= st_ff.halfcyc);

  ////////////////////////////////////////////////////////////////////////
  // Alarm events, each phase compared on its own so any mix can run at once.
  genvar g;
  generate
    for (g = 0; g < NPHASE; g++) begin : g_alarm
      assign ev[g] = sample_valid && al_en[g] && (smp.v_abs[g] > st_ff.vthr);
      assign ev[ST_IAL + g] = sample_valid && al_en[g] && (smp.i_abs[g] > st_ff.ithr);
    end
  endgenerate
  assign ev[ST_DONE] = interval_end;

  pkfm_peak u_peak (
    .clock(clock),
    .sys_rst(sys_rst),
    .smp(smp),
    .phase_en(pk_en),
    .interval_end(interval_end),
    .v_hold(v_hold),
    .i_hold(i_hold)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB: zero wait states, writes take effect in the access phase, reads in the setup phase.
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.zc_out = src_zc;
    if (src_zc) nxt_st.hc_cnt = interval_end ? 16'h0000 : st_ff.hc_cnt + 16'h0001;
    if (wr) begin
      unique case (paddr)
        ADDR_MEASUREMENT_MODE_CONFIG: nxt_st.measurement_mode_config = pwdata[7:0];
        ADDR_HALFCYC: nxt_st.halfcyc = pwdata[15:0];
        ADDR_VTHR: nxt_st.vthr = pwdata[SAMPLE_W-1:0];
        ADDR_ITHR: nxt_st.ithr = pwdata[SAMPLE_W-1:0];
        ADDR_STATUS: nxt_st.status = st_ff.status & ~pwdata[ST_W-1:0];
        ADDR_MASK: nxt_st.mask = pwdata[ST_W-1:0];
        default: ;
      endcase
    end
    // Setting after the clear makes a same-cycle event win over a write-one-clear.
    nxt_st.status = nxt_st.status | ev;
    // Read data is captured in setup so prdata is a flop during access.
    if (rd) begin
      unique case (paddr)
        ADDR_MEASUREMENT_MODE_CONFIG: nxt_st.rdata = {24'h000000, st_ff.measurement_mode_config};
        ADDR_HALFCYC: nxt_st.rdata = {16'h0000, st_ff.halfcyc};
        ADDR_VTHR: nxt_st.rdata = {8'h00, st_ff.vthr};
        ADDR_ITHR: nxt_st.rdata = {8'h00, st_ff.ithr};
        ADDR_VOLTAGE_PEAK_HOLD: nxt_st.rdata = {8'h00, v_hold};
        ADDR_CURRENT_PEAK_HOLD: nxt_st.rdata = {8'h00, i_hold};
        ADDR_STATUS: nxt_st.rdata = {25'h0000000, st_ff.status};
        ADDR_MASK: nxt_st.rdata = {25'h0000000, st_ff.mask};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.measurement_mode_config <= MEASUREMENT_MODE_CONFIG_RST;
      st_ff.halfcyc <= HALFCYC_RST;
      st_ff.vthr <= '1;
      st_ff.ithr <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign line_freq_phase = fsel;
  assign line_freq_zc = st_ff.zc_out;
  // Level interrupt while any unmasked sticky flag stands.
  assign irq = |(st_ff.status & st_ff.mask);
endmodule // pkfm_top
`default_nettype wire

/* tb/pkfm_properties.sv */
`default_nettype none
module pkfm_properties import pkfm_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [NPHASE-1:0] zero_cross,
  input wire logic [1:0] line_freq_phase,
  input wire logic line_freq_zc,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic wr;
  logic rd;
  logic [7:0] mm_ff;
  logic [15:0] hc_ff;
  logic [6:0] mk_ff;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // Shadows of the mode, half-cycle and mask fields, so reads and irq can be judged without peeking inside.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mm_ff <= MEASUREMENT_MODE_CONFIG_RST;
      hc_ff <= HALFCYC_RST;
      mk_ff <= 7'h00;
    end else if (wr) begin
      if (paddr == ADDR_MEASUREMENT_MODE_CONFIG) mm_ff <= pwdata[7:0];
      if (paddr == ADDR_HALFCYC) hc_ff <= pwdata[15:0];
      if (paddr == ADDR_MASK) mk_ff <= pwdata[6:0];
    end
  end
  property p_freq_sel;
    wr && paddr == ADDR_MEASUREMENT_MODE_CONFIG |=> line_freq_phase == mm_ff[1:0];
  endproperty
  a_freq_sel: assert property (p_freq_sel) else $error("frequency source not updated");
  property p_freq_zc;
    !wr && line_freq_phase != 2'h3 && zero_cross[line_freq_phase] |=> line_freq_zc;
  endproperty
  a_freq_zc: assert property (p_freq_zc) else $error("selected crossing lost");
  property p_zc_cause;
    line_freq_zc |-> $past(zero_cross) != 3'h0;
  endproperty
  a_zc_cause: assert property (p_zc_cause) else $error("crossing without cause");
  property p_mm_rb;
    rd && paddr == ADDR_MEASUREMENT_MODE_CONFIG |=> prdata == {24'h0, mm_ff};
  endproperty
  a_mm_rb: assert property (p_mm_rb) else $error("mode readback wrong");
  property p_hc_rb;
    rd && paddr == ADDR_HALFCYC |=> prdata == {16'h0, hc_ff};
  endproperty
  a_hc_rb: assert property (p_hc_rb) else $error("half cycle readback wrong");
  property p_pk_width;
    rd && (paddr == ADDR_VOLTAGE_PEAK_HOLD || paddr == ADDR_CURRENT_PEAK_HOLD)
      |=> prdata[31:24] == 8'h00;
  endproperty
  a_pk_width: assert property (p_pk_width) else $error("peak hold too wide");
  property p_st_width;
    rd && paddr == ADDR_STATUS |=> prdata[31:7] == 25'h0;
  endproperty
  a_st_width: assert property (p_st_width) else $error("status too wide");
  property p_mask_quiet;
    mk_ff == 7'h00 && $past(mk_ff) == 7'h00 |-> !irq;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("irq while masked");
  c_mode_wr: cover property (wr && paddr == ADDR_MEASUREMENT_MODE_CONFIG);
  c_zc: cover property (line_freq_zc);
  c_irq: cover property (irq);
endmodule // pkfm_properties
bind pkfm_top pkfm_properties u_props (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .zero_cross, .line_freq_phase, .line_freq_zc, .irq);
`default_nettype wire

/* tb/pkfm_smp_src.sv */
`default_nettype none
module pkfm_smp_src import pkfm_pkg::*; (
  input wire logic clock,
  input wire logic go,
  input wire logic [SAMPLE_W-1:0] val [6],
  output logic [SAMPLE_W-1:0] smp [6],
  output logic valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial valid = 1'b0;
  initial smp = '{default: '0};
  // Fresh samples only with valid; between them the lines wander, so stale data never looks good.
  always @(posedge clock) begin
    valid <= go;
    for (int k = 0; k < 6; k++) smp[k] <= go ? val[k] : ~smp[k];
  end
endmodule // pkfm_smp_src
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top import pkfm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic pready, pslverr, line_freq_zc, irq, valid;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, vmax, imax, hv;
  logic [1:0] line_freq_phase;
  logic [2:0] zero_cross = 3'h0;
  logic [SAMPLE_W-1:0] val [6] = '{default: '0};
  logic [SAMPLE_W-1:0] smp [6];
  logic [31:0] exp_q [$];
  int failures = 0, check_count = 0, cycles = 0, fsel = 0;
  always #25 clock = ~clock;
  pkfm_top DUT (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .v_abs_a(smp[0]), .v_abs_b(smp[1]), .v_abs_c(smp[2]), .i_abs_a(smp[3]),
    .i_abs_b(smp[4]), .i_abs_c(smp[5]), .sample_valid(valid), .zero_cross,
    .line_freq_phase, .line_freq_zc, .irq);
  pkfm_smp_src u_src (.clock, .go, .val, .smp, .valid);
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // A read notes its expected word; the monitor below pairs it with the answer.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Only phases A and B feed the peaks here, so phase C must never win.
  // Random words are drawn here so they come from the one seeded generator.
  task automatic send(input logic r);
    if (r) foreach (val[k]) val[k] = SAMPLE_W'($urandom);
    for (int k = 0; k < 2; k++) begin
      if (val[k] > vmax) vmax = 32'(val[k]);
      if (val[k+3] > imax) imax = 32'(val[k+3]);
    end
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
  endtask
  task automatic zc(input int p);
    zero_cross <= 3'h1 << p;
    @(posedge clock);
    zero_cross <= 3'h0;
    #1 check(line_freq_zc, 32'(p == fsel));
    @(posedge clock);
  endtask
  // Completed reads are compared with the oldest noted expectation.
  always @(posedge clock) begin
    if (psel && penable && !pwrite && pready) check(prdata, exp_q.pop_front());
    if (psel && penable && pready) check(pslverr, 32'h0);
  end
  // A hang ends the run as a failure.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    void'($urandom(1229));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    apb(0, ADDR_MEASUREMENT_MODE_CONFIG, 32'hfc);
    apb(0, ADDR_HALFCYC, 32'hffff);
    apb(0, 8'h00, 32'h0);
    $display("test reset done");
    apb(1, ADDR_HALFCYC, 32'h2);
    apb(1, ADDR_MEASUREMENT_MODE_CONFIG, 32'h0c);
    hv = 32'h0;
    for (int n = 0; n < 2; n++) begin
      vmax = 32'h0;
      imax = 32'h0;
      repeat (3) send(1);
      zc(0);
      apb(0, ADDR_VOLTAGE_PEAK_HOLD, hv);
      repeat (3) send(1);
      zc(0);
      apb(0, ADDR_VOLTAGE_PEAK_HOLD, vmax);
      apb(0, ADDR_CURRENT_PEAK_HOLD, imax);
      hv = vmax;
    end
    // Alarms were off throughout, so only the interval-done flag may stand.
    apb(0, ADDR_STATUS, 32'h40);
    $display("test peaks done");
    apb(1, ADDR_VTHR, 32'h100);
    apb(1, ADDR_ITHR, 32'h100);
    apb(1, ADDR_MEASUREMENT_MODE_CONFIG, 32'h40);
    apb(1, ADDR_STATUS, 32'h7f);
    apb(1, ADDR_MASK, 32'h7f);
    val = '{24'h200, 24'h101, 24'h100, 24'h100, 24'h100, 24'h200};
    send(0);
    apb(0, ADDR_STATUS, 32'h2);
    check(irq, 32'h1);
    apb(1, ADDR_MEASUREMENT_MODE_CONFIG, 32'he0);
    val = '{24'h100, 24'h100, 24'h100, 24'h101, 24'h100, 24'h101};
    send(0);
    apb(0, ADDR_STATUS, 32'h2a);
    apb(1, ADDR_MASK, 32'h0);
    check(irq, 32'h0);
    apb(1, ADDR_STATUS, 32'h2a);
    apb(0, ADDR_STATUS, 32'h0);
    $display("test alarms done");
    // The reserved source code is never written.
    for (int c = 0; c < 3; c++) begin
      fsel = c;
      apb(1, ADDR_MEASUREMENT_MODE_CONFIG, c);
      check(line_freq_phase, c);
      zc(c);
      zc((c + 1) % 3);
    end
    $display("test frequency done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
